/* File: design/idio_regs.vh */
// Register addresses, field positions and reset values of the digital I/O ports
`ifndef IDIO_REGS_VH
`define IDIO_REGS_VH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define IDIO_ADDR_W 10
`define IDIO_ADDR_CTL_LO 10'h321
`define IDIO_ADDR_INTERNAL 10'h322
`define IDIO_ADDR_STAT_A 10'h323
`define IDIO_ADDR_STAT_B 10'h324
`define IDIO_ADDR_CTL_HI 10'h325

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define IDIO_IN_GROUP_W 6
`define IDIO_OUT_HI_W 4
`define IDIO_PAD_ONES 2'h3
`define IDIO_PAD_OUT_HI 4'hf
`define IDIO_RST_BYTE 8'hff
`define IDIO_RST_NIB 4'hf
`define IDIO_IDLE_BYTE 8'hff
`define IDIO_BIT_HEALTHY 0
`define IDIO_BIT_SEQ 2
`define IDIO_BIT_DIAG 3
`define IDIO_BIT_TEMP 4
`define IDIO_BIT_PRESS 5
`define IDIO_BYTE_W 8
`define IDIO_PAD_BIT 1'b1
`define IDIO_RST_BIT 1'b1

`endif

/* File: design/idio_ports.v */
// Byte-wide digital I/O ports at fixed I/O addresses
`timescale 1ns/1ns
`include "idio_regs.vh"

module idio_ports (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Processor I/O cycle
  input wire [`IDIO_ADDR_W-1:0] ioAddr,
  input wire ioRd,
  input wire ioWr,
  input wire [7:0] ioWrData,
  output reg [7:0] ioRdData_ff,
  // External control inputs, active low
  input wire [11:0] controlIn_n,
  // Internal spare inputs
  input wire [7:0] internalIn,
  // Control outputs, active low
  output reg [7:0] controlOutLo_n_ff,
  output reg [3:0] controlOutHi_n_ff,
  // Spare output ports
  output reg [7:0] internalOut_ff,
  output reg [7:0] statusB_ff,
  // Status port A, all bits
  output reg [7:0] statusA_ff,
  // Named status lines, low active except healthy which is 0 when OK
  output reg system_healthy_out_ff,
  output reg sequence_running_out_n_ff,
  output reg diagnostics_indicator_out_n_ff,
  output reg temperature_fault_out_n_ff,
  output reg pressure_fault_out_n_ff
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // One compare per port, used by the write strobes only; reads decode ioAddr in their own case
  wire hitCtlLo = (ioAddr == `IDIO_ADDR_CTL_LO);
  wire hitCtlHi = (ioAddr == `IDIO_ADDR_CTL_HI);
  wire hitInt = (ioAddr == `IDIO_ADDR_INTERNAL);
  wire hitStA = (ioAddr == `IDIO_ADDR_STAT_A);
  wire hitStB = (ioAddr == `IDIO_ADDR_STAT_B);

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  // Writes to any other address fall away with no trace
  wire wrCtlLo = ioWr && hitCtlLo;
  wire wrCtlHi = ioWr && hitCtlHi;
  wire wrInt = ioWr && hitInt;
  wire wrStA = ioWr && hitStA;
  wire wrStB = ioWr && hitStB;

  // ----------------------------------------
  // Input byte assembly
  // ----------------------------------------
  // Unwired upper bits read as ones, so firmware sees them de-asserted
  wire [`IDIO_BYTE_W-1:0] rdByteCtlLo;
  wire [`IDIO_BYTE_W-1:0] rdByteCtlHi;

  genvar gi;
  generate
    for (gi = 0; gi < `IDIO_BYTE_W; gi = gi + 1) begin : gen_in_bit
      if (gi < `IDIO_IN_GROUP_W) begin : gen_wired
        assign rdByteCtlLo[gi] = controlIn_n[gi];
        assign rdByteCtlHi[gi] = controlIn_n[gi + `IDIO_IN_GROUP_W];
      end else begin : gen_pad
        assign rdByteCtlLo[gi] = `IDIO_PAD_BIT;
        assign rdByteCtlHi[gi] = `IDIO_PAD_BIT;
      end
    end
  endgenerate

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  // Outputs one to eight
  reg [`IDIO_BYTE_W-1:0] nxt_controlOutLo_n;
  always @* begin
    nxt_controlOutLo_n = controlOutLo_n_ff;
    if (wrCtlLo) begin
      nxt_controlOutLo_n = ioWrData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      controlOutLo_n_ff <= `IDIO_RST_BYTE;
    end else begin
      controlOutLo_n_ff <= nxt_controlOutLo_n;
    end
  end

  // Outputs nine to twelve
  reg [`IDIO_OUT_HI_W-1:0] nxt_controlOutHi_n;
  always @* begin
    nxt_controlOutHi_n = controlOutHi_n_ff;
    if (wrCtlHi) begin
      // Upper nibble has no pins and is dropped
      nxt_controlOutHi_n = ioWrData[`IDIO_OUT_HI_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      controlOutHi_n_ff <= `IDIO_RST_NIB;
    end else begin
      controlOutHi_n_ff <= nxt_controlOutHi_n;
    end
  end

  // ----------------------------------------
  // Spare output ports
  // ----------------------------------------
  // Internal spare outputs
  reg [`IDIO_BYTE_W-1:0] nxt_internalOut;
  always @* begin
    nxt_internalOut = internalOut_ff;
    if (wrInt) begin
      nxt_internalOut = ioWrData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      internalOut_ff <= `IDIO_RST_BYTE;
    end else begin
      internalOut_ff <= nxt_internalOut;
    end
  end

  // Status port B, all spare
  reg [`IDIO_BYTE_W-1:0] nxt_statusB;
  always @* begin
    nxt_statusB = statusB_ff;
    if (wrStB) begin
      nxt_statusB = ioWrData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      statusB_ff <= `IDIO_RST_BYTE;
    end else begin
      statusB_ff <= nxt_statusB;
    end
  end

  // ----------------------------------------
  // Status port A
  // ----------------------------------------
  // Named lines take the next byte, so they never lag the port by a cycle
  reg [`IDIO_BYTE_W-1:0] nxt_statusA;
  always @* begin
    nxt_statusA = statusA_ff;
    if (wrStA) begin
      nxt_statusA = ioWrData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      statusA_ff <= `IDIO_RST_BYTE;
    end else begin
      statusA_ff <= nxt_statusA;
    end
  end

  // ----------------------------------------
  // Named status lines
  // ----------------------------------------
  // Healthy line, 0 when all is well
  reg nxt_systemHealthy;
  always @* begin
    nxt_systemHealthy = nxt_statusA[`IDIO_BIT_HEALTHY];
  end

  always @(posedge clk) begin
    if (rst) begin
      system_healthy_out_ff <= `IDIO_RST_BIT;
    end else begin
      system_healthy_out_ff <= nxt_systemHealthy;
    end
  end

  // Sequence line, low while a sequence runs
  reg nxt_sequenceRunning_n;
  always @* begin
    nxt_sequenceRunning_n = nxt_statusA[`IDIO_BIT_SEQ];
  end

  always @(posedge clk) begin
    if (rst) begin
      sequence_running_out_n_ff <= `IDIO_RST_BIT;
    end else begin
      sequence_running_out_n_ff <= nxt_sequenceRunning_n;
    end
  end

  // Diagnostics line, low in diagnostic mode
  reg nxt_diagnostics_n;
  always @* begin
    nxt_diagnostics_n = nxt_statusA[`IDIO_BIT_DIAG];
  end

  always @(posedge clk) begin
    if (rst) begin
      diagnostics_indicator_out_n_ff <= `IDIO_RST_BIT;
    end else begin
      diagnostics_indicator_out_n_ff <= nxt_diagnostics_n;
    end
  end

  // Temperature line, low on any temperature alarm
  reg nxt_temperatureFault_n;
  always @* begin
    nxt_temperatureFault_n = nxt_statusA[`IDIO_BIT_TEMP];
  end

  always @(posedge clk) begin
    if (rst) begin
      temperature_fault_out_n_ff <= `IDIO_RST_BIT;
    end else begin
      temperature_fault_out_n_ff <= nxt_temperatureFault_n;
    end
  end

  // Pressure line, low on any pressure alarm
  reg nxt_pressureFault_n;
  always @* begin
    nxt_pressureFault_n = nxt_statusA[`IDIO_BIT_PRESS];
  end

  always @(posedge clk) begin
    if (rst) begin
      pressure_fault_out_n_ff <= `IDIO_RST_BIT;
    end else begin
      pressure_fault_out_n_ff <= nxt_pressureFault_n;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Write-only and unmapped addresses read as all ones, like an undriven bus
  reg [`IDIO_BYTE_W-1:0] nxt_ioRdData;
  always @* begin
    nxt_ioRdData = ioRdData_ff;
    if (ioRd) begin
      case (ioAddr)
        `IDIO_ADDR_CTL_LO: begin
          nxt_ioRdData = rdByteCtlLo;
        end
        `IDIO_ADDR_CTL_HI: begin
          nxt_ioRdData = rdByteCtlHi;
        end
        `IDIO_ADDR_INTERNAL: begin
          nxt_ioRdData = internalIn;
        end
        `IDIO_ADDR_STAT_A: begin
          nxt_ioRdData = `IDIO_IDLE_BYTE;
        end
        `IDIO_ADDR_STAT_B: begin
          nxt_ioRdData = `IDIO_IDLE_BYTE;
        end
        default: begin
          nxt_ioRdData = `IDIO_IDLE_BYTE;
        end
      endcase
    end
  end

  // Holds the last read until the next one, so firmware may sample late
  always @(posedge clk) begin
    if (rst) begin
      ioRdData_ff <= `IDIO_IDLE_BYTE;
    end else begin
      ioRdData_ff <= nxt_ioRdData;
    end
  end

endmodule

/* File: verif/idio_ports_chk.sv */
// Assertion checker for the digital I/O ports
`timescale 1ns/1ns
module idio_ports_chk (
  // Clock, reset and I/O cycle
  input wire clk, rst, ioRd, ioWr,
  input wire [9:0] ioAddr,
  input wire [7:0] ioWrData, ioRdData_ff, controlOutLo_n_ff, statusA_ff,
  // Pins
  input wire [11:0] controlIn_n,
  input wire [3:0] controlOutHi_n_ff,
  input wire system_healthy_out_ff, sequence_running_out_n_ff, pressure_fault_out_n_ff,
  input wire diagnostics_indicator_out_n_ff, temperature_fault_out_n_ff,
  input wire [7:0] internalIn, internalOut_ff, statusB_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RD_LO: assert property (ioRd && ioAddr == 10'h321 |=>
    ioRdData_ff == {2'h3, $past(controlIn_n[5:0])}) else $error("low read");
  AST_RD_HI: assert property (ioRd && ioAddr == 10'h325 |=>
    ioRdData_ff == {2'h3, $past(controlIn_n[11:6])}) else $error("high read");
  AST_WR_LO: assert property (ioWr && ioAddr == 10'h321 |=>
    controlOutLo_n_ff == $past(ioWrData)) else $error("low write");
  AST_WR_HI: assert property (ioWr && ioAddr == 10'h325 |=>
    controlOutHi_n_ff == $past(ioWrData[3:0])) else $error("high write");
  AST_HEALTHY: assert property (system_healthy_out_ff == statusA_ff[0])
    else $error("healthy line");
  AST_SEQ: assert property (sequence_running_out_n_ff == statusA_ff[2])
    else $error("sequence line");
  AST_PRESS: assert property (pressure_fault_out_n_ff == statusA_ff[5])
    else $error("pressure line");
  AST_DIAG: assert property (diagnostics_indicator_out_n_ff == statusA_ff[3])
    else $error("diagnostics line");
  AST_TEMP: assert property (temperature_fault_out_n_ff == statusA_ff[4])
    else $error("temperature line");
  AST_RD_INT: assert property (ioRd && ioAddr == 10'h322 |=>
    ioRdData_ff == $past(internalIn)) else $error("internal read");
  AST_WR_INT: assert property (ioWr && ioAddr == 10'h322 |=>
    internalOut_ff == $past(ioWrData)) else $error("internal write");
  AST_WR_B: assert property (ioWr && ioAddr == 10'h324 |=>
    statusB_ff == $past(ioWrData)) else $error("status b write");
  AST_RST: assert property ($fell(rst) |-> controlOutLo_n_ff == 8'hff)
    else $error("reset level");
  cover property (ioWr && ioAddr == 10'h323);
  cover property (ioRd && ioAddr == 10'h325);
  cover property (ioRd && ioWr);
endmodule
bind idio_ports idio_ports_chk idio_ports_chk_inst (.*);

/* File: verif/idio_ext_model.sv */
// Model of the equipment wired to the input pins
`timescale 1ns/1ns
module idio_ext_model (
  input wire clk,
  input wire [7:0] pattern,
  output logic [11:0] controlIn_n = 12'hfff,
  output logic [7:0] internalIn = 8'hff
);
  // Levels move on the rising edge, one cycle after pattern changes
  // High group inverted so a swap of the two groups shows up
  // Relay watchdog toggling is firmware's work on another bus, not modelled
  always @(posedge clk) begin
    controlIn_n <= {~pattern[5:0], pattern[5:0]};
    internalIn <= pattern;
  end
endmodule

/* File: verif/tb_idio_ports.sv */
// Self-checking bench for the digital I/O ports
`timescale 1ns/1ns
module tb_idio_ports;
  logic clk = 0, rst = 1, ioRd = 0, ioWr = 0;
  logic [9:0] ioAddr = 10'h0;
  logic [7:0] ioWrData = 8'h0, pattern = 8'hff, ioRdData_ff, controlOutLo_n_ff, internalOut_ff;
  logic [7:0] statusA_ff, statusB_ff, internalIn;
  logic [11:0] controlIn_n;
  logic [3:0] controlOutHi_n_ff;
  wire [4:0] nm;
  // Address, data, expected read; unmapped reads give all ones
  logic [25:0] rows [6] = '{{10'h321, 8'ha5, 8'he5}, {10'h322, 8'h3c, 8'h3c},
    {10'h323, 8'hc2, 8'hff}, {10'h324, 8'h5a, 8'hff}, {10'h325, 8'h96, 8'he9},
    {10'h300, 8'h00, 8'hff}};
  int errors = 0, samples_checked = 0;
  idio_ext_model idio_ext_model_inst (.*);
  idio_ports idio_ports_inst (.*, .system_healthy_out_ff(nm[4]), .sequence_running_out_n_ff(nm[3]),
    .diagnostics_indicator_out_n_ff(nm[2]), .temperature_fault_out_n_ff(nm[1]),
    .pressure_fault_out_n_ff(nm[0]));
  task chk(input string n, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #2 clk = ~clk;
  initial begin
    #2000 errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 chk("reset", {controlOutLo_n_ff, controlOutHi_n_ff, internalOut_ff, statusA_ff, nm}, 33'h1ffffffff);
    foreach (rows[i]) begin
      @(posedge clk) pattern <= rows[i][15:8];
      @(posedge clk) {ioAddr, ioWrData, ioRd, ioWr} <= {rows[i][25:8], 2'h3};
      @(posedge clk) {ioRd, ioWr} <= 2'h0;
      #1 chk("read", ioRdData_ff, rows[i][7:0]);
    end
    chk("ports", {controlOutLo_n_ff, controlOutHi_n_ff, internalOut_ff, statusA_ff, statusB_ff},
      {8'ha5, 4'h6, 8'h3c, 8'hc2, 8'h5a});
    chk("status", nm, 5'h0);
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 chk("rerun", {controlOutLo_n_ff, controlOutHi_n_ff, internalOut_ff, statusA_ff, statusB_ff,
      nm, ioRdData_ff}, 49'h1ffffffffffff);
    @(posedge clk) {ioAddr, ioWrData, ioWr} <= {10'h323, 8'hfe, 1'b1};
    @(posedge clk) ioWr <= 0;
    #1 chk("first write", nm, 5'h0f);
    stop_test();
  end
endmodule
